// [hw/label_validator.sv]
// The implementer's own choices: the APB register port and the placing of the registers.
`timescale 1ns/1ns
// Operation
// - extent start below track 1 sector 1 invalid
// - sector 00 or above 26 invalid
// - extent start middle digit must be 0
// - extent end above 74/26 invalid
// - extent end middle digit must be 0
// - data end within start and end plus one
// - data end above 75/01 invalid
// - data end middle digit must be 0
// - bypass B on read/write gives unit check
// - bypassed label ends command, no search
// - write protect P on writes gives check
// - record length 1 to 128 else invalid
// - read labels; track-zero bit marks label fault
// - deleted label on index read: exception
// - reads skip deleted labels to next
// - plain read withholds deleted records silently
// - read-deleted passes deleted records, exception
// - valid only with header-one identifier
// - non-blank access byte blocks processing
// - changed data set clears verify V
// - each written record updates data end
// - extent addresses taken from fixed positions
// - address is track, head, sector digits
module label_validator #(
   parameter int ADDR_W = 8
) (
   // clock and reset
   input  wire logic              clk,
   input  wire logic              sys_rst,
   // apb slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic                   pready,
   output logic [31:0]            prdata,
   output logic                   pslverr,
   // sector stream from drive
   input  wire logic              sec_valid,
   input  wire logic              sec_start,
   input  wire logic              sec_end,
   input  wire logic              sec_del_mark,
   input  wire logic [7:0]        sec_byte,
   input  wire logic              drive_fault,
   // record data toward host channel
   output logic                   rd_valid,
   output logic [7:0]             rd_byte,
   output logic                   cmd_end
);

   typedef enum logic [1:0] {ST_IDLE, ST_LABEL, ST_CHECK, ST_DATA} state_e;

   state_e                state_q;
   logic [2:0]            op_q;
   logic [6:0]            pos_q;
   logic                  ldel_q;
   logic [7:0]            lbl_q [1:label_pkg::LABEL_LEN];
   label_pkg::disk_addr_s cur_q;
   label_pkg::disk_addr_s dend_q;
   logic                  verify_q;
   logic                  rec_del_q;
   label_pkg::sense_s     sense_q;
   label_pkg::status_s    stat_q;
   logic                  pready_q;
   logic [31:0]           prdata_q;
   logic                  pslverr_q;
   logic                  rd_valid_q;
   logic [7:0]            rd_byte_q;
   logic                  cmd_end_q;

   // ebcdic digit helpers
   function automatic logic is_dig(input logic [7:0] b);
      return (b[7:4] == 4'hF) && (b[3:0] <= 4'h9);
   endfunction

   function automatic logic [6:0] two_dig(input logic [7:0] hi,
                                          input logic [7:0] lo);
      return 7'(hi[3:0]) * 7'h0A + 7'(lo[3:0]);
   endfunction

   function automatic logic [16:0] rlen_dig(input logic [16:0] acc,
                                            input logic [7:0] b);
      return 17'(acc * 17'h0000A) + 17'(b[3:0]);
   endfunction

   // next sector address, wrapping to sector 1 of next track
   function automatic label_pkg::disk_addr_s adr_next(
         input label_pkg::disk_addr_s a);
      label_pkg::disk_addr_s n;
      n = a;
      if (a.sector >= label_pkg::SEC_MAX) begin
         n.track  = a.track + 7'h01;
         n.sector = label_pkg::SEC_MIN;
      end else begin
         n.sector = a.sector + 7'h01;
      end
      return n;
   endfunction

   // address field check: digits, head 0, sector 1..26
   function automatic logic adr_bad(input logic [7:0] b0,
                                    input logic [7:0] b1,
                                    input logic [7:0] b2,
                                    input logic [7:0] b3,
                                    input logic [7:0] b4);
      logic [6:0] s;
      s = two_dig(b3, b4);
      return !is_dig(b0) || !is_dig(b1) || (b2 != label_pkg::CH_ZERO)
             || !is_dig(b3) || !is_dig(b4)
             || (s == 7'h00) || (s > label_pkg::SEC_MAX);
   endfunction

   // field extraction from the stored label
   label_pkg::disk_addr_s xst_w;
   label_pkg::disk_addr_s xen_w;
   label_pkg::disk_addr_s dend_w;
   label_pkg::disk_addr_s xen_next_w;
   label_pkg::disk_addr_s cur_next_w;
   logic [16:0]           rlen_w;
   logic                  rlen_fmt_bad_w;
   logic [31:0]           ident_w;

   assign xst_w.track  = two_dig(lbl_q[29], lbl_q[30]);
   assign xst_w.sector = two_dig(lbl_q[32], lbl_q[33]);
   assign xen_w.track  = two_dig(lbl_q[35], lbl_q[36]);
   assign xen_w.sector = two_dig(lbl_q[38], lbl_q[39]);
   assign dend_w.track  = two_dig(lbl_q[75], lbl_q[76]);
   assign dend_w.sector = two_dig(lbl_q[78], lbl_q[79]);
   assign xen_next_w = adr_next(xen_w);
   assign cur_next_w = adr_next(cur_q);
   assign ident_w = {lbl_q[1], lbl_q[2], lbl_q[3], lbl_q[4]};

   // record length: leading blanks count as zero
   always_comb begin
      rlen_w = 17'h00000;
      rlen_fmt_bad_w = 1'b0;
      for (int i = label_pkg::POS_RECLEN; i < label_pkg::POS_RECLEN + 5;
           i++) begin
         if (lbl_q[i] == label_pkg::CH_BLANK) begin
            rlen_w = rlen_dig(rlen_w, 8'hF0);
         end else begin
            rlen_w = rlen_dig(rlen_w, lbl_q[i]);
            if (!is_dig(lbl_q[i])) begin
               rlen_fmt_bad_w = 1'b1;
            end
         end
      end
   end

   // label check terms
   logic xst_bad_w;
   logic xen_bad_w;
   logic dend_bad_w;
   logic rlen_bad_w;
   logic bypass_w;
   logic access_w;
   logic wprot_w;
   logic is_write_w;
   logic is_read_w;
   logic deleted_w;
   logic invalid_w;

   assign xst_bad_w = adr_bad(lbl_q[29], lbl_q[30], lbl_q[31], lbl_q[32],
                              lbl_q[33])
                   || (xst_w < {label_pkg::TRK_MIN,
                                label_pkg::SEC_MIN});
   assign xen_bad_w = adr_bad(lbl_q[35], lbl_q[36], lbl_q[37], lbl_q[38],
                              lbl_q[39])
                   || (xen_w > {label_pkg::XEN_TRK,
                                label_pkg::SEC_MAX});
   assign dend_bad_w = adr_bad(lbl_q[75], lbl_q[76], lbl_q[77], lbl_q[78],
                               lbl_q[79])
                    || (dend_w < xst_w) || (dend_w > xen_next_w)
                    || (dend_w > {label_pkg::DEND_TRK,
                                  label_pkg::SEC_MIN});
   assign rlen_bad_w = rlen_fmt_bad_w || (rlen_w < label_pkg::RLEN_MIN)
                    || (rlen_w > label_pkg::RLEN_MAX);
   assign is_write_w = (op_q == label_pkg::OP_WRITE)
                    || (op_q == label_pkg::OP_WRITE_DEL);
   assign is_read_w  = (op_q == label_pkg::OP_READ)
                    || (op_q == label_pkg::OP_READ_DEL);
   assign bypass_w = (lbl_q[41] == label_pkg::CH_B)
                  && (is_read_w || is_write_w);
   assign access_w = (lbl_q[42] != label_pkg::CH_BLANK);
   assign wprot_w  = is_write_w && (lbl_q[43] == label_pkg::CH_P);
   assign deleted_w = ldel_q || (ident_w != label_pkg::ID_VALID);
   assign invalid_w = xst_bad_w || xen_bad_w || dend_bad_w || rlen_bad_w
                   || bypass_w || access_w;

   // apb decode
   logic        apb_acc_w;
   logic        apb_wr_w;
   logic        hit_w;
   logic [31:0] rd_mux_w;
   logic        start_w;
   logic        abort_w;

   assign apb_acc_w = psel && penable && !pready_q;
   assign apb_wr_w  = psel && penable && pready_q && pwrite;
   assign hit_w = (paddr == ADDR_W'(label_pkg::OFS_CTRL))
               || (paddr == ADDR_W'(label_pkg::OFS_STATUS))
               || (paddr == ADDR_W'(label_pkg::OFS_SENSE))
               || (paddr == ADDR_W'(label_pkg::OFS_DEND))
               || (paddr == ADDR_W'(label_pkg::OFS_EXTENT));
   assign start_w = apb_wr_w && (state_q == ST_IDLE)
                 && (paddr == ADDR_W'(label_pkg::OFS_CTRL))
                 && pwdata[label_pkg::CTRL_START];
   assign abort_w = apb_wr_w && (state_q != ST_IDLE)
                 && (paddr == ADDR_W'(label_pkg::OFS_CTRL))
                 && pwdata[label_pkg::CTRL_ABORT];
   assign rd_mux_w =
      (paddr == ADDR_W'(label_pkg::OFS_CTRL))   ? {29'h0, op_q} :
      (paddr == ADDR_W'(label_pkg::OFS_STATUS)) ?
         {27'h0, state_q != ST_IDLE, 1'b0, stat_q} :
      (paddr == ADDR_W'(label_pkg::OFS_SENSE))  ? {27'h0, sense_q} :
      (paddr == ADDR_W'(label_pkg::OFS_DEND))   ?
         {15'h0, verify_q, 2'h0, dend_q} :
      (paddr == ADDR_W'(label_pkg::OFS_EXTENT)) ?
         {2'h0, xen_w, 2'h0, xst_w} : 32'h0000_0000;

   // apb answer one cycle into the access phase
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pready_q  <= 1'b0;
         prdata_q  <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end else begin
         pready_q <= apb_acc_w;
         if (apb_acc_w) begin
            prdata_q  <= hit_w ? rd_mux_w : 32'h0000_0000;
            pslverr_q <= !hit_w;
         end else begin
            pslverr_q <= 1'b0;
         end
      end
   end

   // label byte capture, first byte of a sector lands at position 1
   always_ff @(posedge clk) begin
      if ((state_q == ST_LABEL) && sec_valid && sec_start) begin
         lbl_q[1] <= sec_byte;
      end else if ((state_q == ST_LABEL) && sec_valid && (pos_q != 7'h00)
                   && (pos_q <= 7'(label_pkg::LABEL_LEN))) begin
         lbl_q[pos_q] <= sec_byte;
      end
   end

   // record pass decision for the current data sector
   logic rec_del_w;
   logic pass_w;
   assign rec_del_w = sec_start ? sec_del_mark : rec_del_q;
   assign pass_w = (state_q == ST_DATA) && sec_valid && is_read_w
                && !(rec_del_w && (op_q == label_pkg::OP_READ));

   // command sequencer
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_q    <= ST_IDLE;
         op_q       <= label_pkg::OP_READ;
         pos_q      <= 7'h00;
         ldel_q     <= 1'b0;
         rec_del_q  <= 1'b0;
         cur_q      <= '0;
         dend_q     <= '0;
         verify_q   <= 1'b0;
         sense_q    <= '0;
         stat_q     <= '0;
         rd_valid_q <= 1'b0;
         rd_byte_q  <= 8'h00;
         cmd_end_q  <= 1'b0;
      end else begin
         cmd_end_q  <= 1'b0;
         rd_valid_q <= pass_w;
         if (pass_w) begin
            rd_byte_q <= sec_byte;
         end
         case (state_q)
            ST_IDLE: begin
               if (start_w) begin
                  op_q     <= pwdata[label_pkg::CTRL_OP_LSB +: 3];
                  sense_q  <= '0;
                  stat_q   <= '0;
                  verify_q <= 1'b0;
                  state_q  <= ST_LABEL;
               end
            end
            ST_LABEL: begin
               if (sec_valid) begin
                  if (sec_start) begin
                     pos_q  <= 7'h02;
                     ldel_q <= sec_del_mark;
                  end else begin
                     pos_q <= pos_q + 7'h01;
                  end
                  if (sec_end) begin
                     state_q <= ST_CHECK;
                  end
               end
            end
            ST_CHECK: begin
               pos_q <= 7'h00;
               if (op_q == label_pkg::OP_RIDX_DEL) begin
                  if (deleted_w) begin
                     stat_q.unit_exception      <= 1'b1;
                     sense_q.deleted_label_mark <= 1'b1;
                  end
                  stat_q.device_end <= 1'b1;
                  cmd_end_q <= 1'b1;
                  state_q   <= ST_IDLE;
               end else if (deleted_w && is_read_w) begin
                  state_q <= ST_LABEL;
               end else if (deleted_w || invalid_w) begin
                  sense_q.invalid_label        <= 1'b1;
                  sense_q.track_zero_sense_bit <= 1'b1;
                  stat_q.unit_check <= 1'b1;
                  stat_q.device_end <= 1'b1;
                  cmd_end_q <= 1'b1;
                  state_q   <= ST_IDLE;
               end else if (wprot_w) begin
                  sense_q.write_protect        <= 1'b1;
                  sense_q.track_zero_sense_bit <= 1'b1;
                  stat_q.unit_check <= 1'b1;
                  stat_q.device_end <= 1'b1;
                  cmd_end_q <= 1'b1;
                  state_q   <= ST_IDLE;
               end else begin
                  cur_q    <= xst_w;
                  dend_q   <= dend_w;
                  verify_q <= (lbl_q[73] == label_pkg::CH_V);
                  state_q  <= (is_read_w && (dend_w == xst_w)) ?
                              ST_IDLE : ST_DATA;
                  if (is_read_w && (dend_w == xst_w)) begin
                     stat_q.device_end <= 1'b1;
                     cmd_end_q <= 1'b1;
                  end
               end
            end
            ST_DATA: begin
               if (sec_valid && sec_start) begin
                  rec_del_q <= sec_del_mark;
               end
               if (pass_w && rec_del_w
                   && (op_q == label_pkg::OP_READ_DEL)) begin
                  stat_q.unit_exception     <= 1'b1;
                  sense_q.deleted_data_mark <= 1'b1;
               end
               if (sec_valid && sec_end) begin
                  cur_q <= cur_next_w;
                  if (is_write_w) begin
                     dend_q   <= cur_next_w;
                     verify_q <= 1'b0;
                  end
                  if ((is_read_w && (cur_next_w == dend_q))
                      || (is_write_w && (cur_next_w > xen_w))) begin
                     stat_q.device_end <= 1'b1;
                     cmd_end_q <= 1'b1;
                     state_q   <= ST_IDLE;
                  end
               end
            end
            default: state_q <= ST_IDLE;
         endcase
         // drive fault: track-zero bit tells label from data phase
         if (drive_fault && (state_q != ST_IDLE)) begin
            sense_q.track_zero_sense_bit <= (state_q != ST_DATA);
            stat_q.unit_check <= 1'b1;
            stat_q.device_end <= 1'b1;
            cmd_end_q <= 1'b1;
            state_q   <= ST_IDLE;
         end else if (abort_w) begin
            stat_q.device_end <= 1'b1;
            cmd_end_q <= 1'b1;
            state_q   <= ST_IDLE;
         end
      end
   end

   // outputs straight from flops
   assign pready  = pready_q;
   assign prdata  = prdata_q;
   assign pslverr = pslverr_q;
   assign rd_valid = rd_valid_q;
   assign rd_byte  = rd_byte_q;
   assign cmd_end  = cmd_end_q;

endmodule // label_validator

// [include/label_pkg.sv]
package label_pkg;
   // apb register byte offsets
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_SENSE  = 8'h08;
   localparam logic [7:0] OFS_DEND   = 8'h0C;
   localparam logic [7:0] OFS_EXTENT = 8'h10;
   // control register fields
   localparam int CTRL_OP_LSB = 0;
   localparam int CTRL_START  = 8;
   localparam int CTRL_ABORT  = 9;
   // command codes
   localparam logic [2:0] OP_READ      = 3'h0;
   localparam logic [2:0] OP_READ_DEL  = 3'h1;
   localparam logic [2:0] OP_WRITE     = 3'h2;
   localparam logic [2:0] OP_WRITE_DEL = 3'h3;
   localparam logic [2:0] OP_RIDX_DEL  = 3'h4;
   // label byte positions
   localparam int POS_ID     = 1;
   localparam int POS_RECLEN = 23;
   localparam int POS_XST    = 29;
   localparam int POS_XEN    = 35;
   localparam int POS_BYPASS = 41;
   localparam int POS_ACCESS = 42;
   localparam int POS_WPROT  = 43;
   localparam int POS_VERIFY = 73;
   localparam int POS_DEND   = 75;
   localparam int LABEL_LEN  = 80;
   // ebcdic characters
   localparam logic [7:0] CH_BLANK = 8'h40;
   localparam logic [7:0] CH_ZERO  = 8'hF0;
   localparam logic [7:0] CH_B     = 8'hC2;
   localparam logic [7:0] CH_P     = 8'hD7;
   localparam logic [7:0] CH_V     = 8'hE5;
   localparam logic [31:0] ID_VALID = 32'hC8C4D9F1;
   // geometry limits
   localparam logic [6:0] SEC_MAX    = 7'h1A;
   localparam logic [6:0] SEC_MIN    = 7'h01;
   localparam logic [6:0] TRK_MIN    = 7'h01;
   localparam logic [6:0] XEN_TRK    = 7'h4A;
   localparam logic [6:0] DEND_TRK   = 7'h4B;
   localparam logic [16:0] RLEN_MIN  = 17'h00001;
   localparam logic [16:0] RLEN_MAX  = 17'h00080;

   typedef struct packed {
      logic [6:0] track;
      logic [6:0] sector;
   } disk_addr_s;

   typedef struct packed {
      logic invalid_label;
      logic write_protect;
      logic track_zero_sense_bit;
      logic deleted_label_mark;
      logic deleted_data_mark;
   } sense_s;

   typedef struct packed {
      logic device_end;
      logic unit_check;
      logic unit_exception;
   } status_s;
endpackage

// [verif/drive_model.sv]
`timescale 1ns/1ns
// drive side: streams one sector per go pulse
module drive_model (
   // clock
   input  wire logic          clk,
   // request from bench
   input  wire logic          go,
   input  wire logic          del,
   input  wire logic [7:0]    len,
   input  wire logic [1023:0] img,
   // sector stream
   output logic               sec_valid,
   output logic               sec_start,
   output logic               sec_end,
   output logic               sec_del_mark,
   output logic [7:0]         sec_byte,
   output logic               busy
);
   int idx;
   // quiet outputs at time zero
   initial begin
      {sec_valid, sec_start, sec_end, sec_del_mark, busy} = 5'h00;
      sec_byte = 8'hA5;
   end
   // byte sequencer, data line toggles while idle
   always @(posedge clk) begin
      if (go && !busy) begin
         busy <= 1'b1;
         idx = 0;
      end
      if (busy && idx < int'(len)) begin
         sec_valid    <= 1'b1;
         sec_start    <= (idx == 0);
         sec_end      <= (idx == int'(len) - 1);
         sec_del_mark <= del && (idx == 0);
         sec_byte     <= img[1023 - 8*idx -: 8];
         idx = idx + 1;
      end else begin
         {sec_valid, sec_start, sec_end, sec_del_mark} <= 4'h0;
         sec_byte <= ~sec_byte;
         if (busy) begin
            busy <= 1'b0;
         end
      end
   end
endmodule // drive_model

// [verif/label_validator_props.sv]
`timescale 1ns/1ns
// port checks for the label validator
module label_validator_props #(
   parameter int ADDR_W = 8
) (
   // clock and reset
   input wire logic              clk,
   input wire logic              sys_rst,
   // apb slave
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0]       pwdata,
   input wire logic              pready,
   input wire logic [31:0]       prdata,
   input wire logic              pslverr,
   // drive stream
   input wire logic              sec_valid,
   input wire logic              sec_start,
   input wire logic              sec_end,
   input wire logic              sec_del_mark,
   input wire logic [7:0]        sec_byte,
   input wire logic              drive_fault,
   // host channel
   input wire logic              rd_valid,
   input wire logic [7:0]        rd_byte,
   input wire logic              cmd_end
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   // apb answer timing
   ready_second_a: assert property ($rose(penable) && psel |-> !pready ##1 pready)
      else $error("pready not on second access cycle");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   ready_cause_a: assert property (pready |-> $past(psel && penable))
      else $error("pready without access phase");
   err_zero_a: assert property (pslverr |-> pready && prdata == 32'h0)
      else $error("slave error without ready or with data");
   unmapped_a: assert property ($rose(penable) && psel && paddr > 'h10 |=> pslverr)
      else $error("unmapped address not refused");
   // record path and ending
   rd_from_byte_a: assert property (rd_valid |-> $past(sec_valid) && rd_byte == $past(sec_byte))
      else $error("record byte not taken from drive byte");
   end_pulse_a: assert property (cmd_end |=> !cmd_end)
      else $error("command end longer than one cycle");
   reset_quiet_a: assert property ($fell(sys_rst) |-> !pready && !rd_valid && !cmd_end)
      else $error("output active at first edge after reset");

   // main scenarios
   end_c: cover property (cmd_end);
   rd_c: cover property (rd_valid);
   err_c: cover property (pready && pslverr);
endmodule // label_validator_props

bind label_validator label_validator_props #(.ADDR_W(ADDR_W)) u_props (
   .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
   .prdata(prdata), .pslverr(pslverr), .sec_valid(sec_valid),
   .sec_start(sec_start), .sec_end(sec_end), .sec_del_mark(sec_del_mark),
   .sec_byte(sec_byte), .drive_fault(drive_fault), .rd_valid(rd_valid),
   .rd_byte(rd_byte), .cmd_end(cmd_end));

// [verif/tb_top.sv]
`timescale 1ns/1ns
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin \
   n_fail++; $display("wrong value at %0t: %h expected %h", \
   $time, got, exp); end end
// bench: apb host and drive model around the label validator
module tb_top;
   logic          clk, sys_rst, psel, penable, pwrite, pready, pslverr;
   logic          sec_valid, sec_start, sec_end, sec_del_mark;
   logic          rd_valid, cmd_end, go, del, busy, rerr, flt;
   logic [7:0]    paddr, sec_byte, rd_byte, len, last_rd;
   logic [31:0]   pwdata, prdata, rdat;
   logic [1023:0] img, lbl, base, dlbl, dat;
   int            n_fail, num_checks, rd_cnt, cyc, i, op;

   label_validator u_dut (.clk(clk), .sys_rst(sys_rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .sec_valid(sec_valid), .sec_start(sec_start), .sec_end(sec_end),
      .sec_del_mark(sec_del_mark), .sec_byte(sec_byte),
      .drive_fault(flt), .rd_valid(rd_valid), .rd_byte(rd_byte),
      .cmd_end(cmd_end));
   drive_model u_drive (.clk(clk), .go(go), .del(del), .len(len),
      .img(img), .sec_valid(sec_valid), .sec_start(sec_start),
      .sec_end(sec_end), .sec_del_mark(sec_del_mark),
      .sec_byte(sec_byte), .busy(busy));

   // clock
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // record counter and hang limit
   always @(posedge clk) begin
      cyc++;
      if (rd_valid === 1'b1) begin
         rd_cnt++;
         last_rd = rd_byte;
      end
      if (cyc == 60000) begin
         n_fail++;
         print_verdict();
      end
   end

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // one apb transfer, waits for pready
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic start(input int o);
      rd_cnt = 0;
      apb(1'b1, label_pkg::OFS_CTRL, 32'h100 | 32'(o));
   endtask
   task automatic send(input logic d, input logic [7:0] n,
                       input logic [1023:0] s);
      img <= s;
      len <= n;
      del <= d;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      @(posedge clk);
      while (busy === 1'b1) @(posedge clk);
   endtask
   // wait for ending, then read status and sense
   task automatic finish(input logic [31:0] st, input logic [31:0] sn,
                         input logic [31:0] m);
      for (int k = 0; k < 3000 && cmd_end !== 1'b1; k++) @(posedge clk);
      @(posedge clk);
      apb(1'b0, label_pkg::OFS_STATUS, 32'h0);
      `CHK(rdat, st)
      apb(1'b0, label_pkg::OFS_SENSE, 32'h0);
      `CHK(rdat & m, sn)
   endtask
   task automatic put(input int p, input int v);
      lbl[1023 - 8*(p-1) -: 8] = 8'(v);
   endtask
   task automatic put_addr(input int p, input int t, input int s);
      put(p, 'hF0 + t / 10);
      put(p + 1, 'hF0 + t % 10);
      put(p + 2, 'hF0);
      put(p + 3, 'hF0 + s / 10);
      put(p + 4, 'hF0 + s % 10);
   endtask

   initial begin
      {sys_rst, psel, penable, pwrite, go, del, flt} = 7'h40;
      {paddr, pwdata, len, img} = '0;
      // reference label: reclen 4, extent 01001-01002, data end 01002
      lbl = {128{label_pkg::CH_BLANK}};
      lbl[1023 -: 32] = label_pkg::ID_VALID;
      for (i = 23; i < 28; i++) put(i, (i == 27) ? 'hF4 : 'hF0);
      put_addr(29, 1, 1);
      put_addr(35, 1, 2);
      put_addr(75, 1, 2);
      put(73, label_pkg::CH_V);
      base = lbl;
      dlbl = lbl;
      dlbl[1023 -: 32] = 32'hC4C4D9F1;
      dat = {32'h11223344, 992'h0};
      repeat (5) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      // deleted label skipped, one record passed
      start(label_pkg::OP_READ);
      send(1'b1, 8'd80, dlbl);
      send(1'b0, 8'd80, base);
      send(1'b0, 8'd4, dat);
      finish(32'h4, 32'h0, 32'h1B);
      `CHK(rd_cnt, 4)
      `CHK(last_rd, 8'h44)
      apb(1'b0, label_pkg::OFS_EXTENT, 32'h0);
      `CHK(rdat, 32'h00820081)
      apb(1'b0, label_pkg::OFS_DEND, 32'h0);
      `CHK(rdat, 32'h00010082)
      // deleted record: plain read withholds it, read-deleted passes it
      for (op = 0; op < 2; op++) begin
         start(op);
         send(1'b0, 8'd80, base);
         send(1'b1, 8'd4, dat);
         finish(op ? 32'h5 : 32'h4, 32'(op), 32'h1B);
         `CHK(rd_cnt, op * 4)
      end
      // deleted label on read-index-deleted
      start(label_pkg::OP_RIDX_DEL);
      send(1'b1, 8'd80, dlbl);
      finish(32'h5, 32'h2, 32'h1B);
      // faulty labels on a plain read
      for (i = 0; i < 14; i++) begin
         lbl = base;
         case (i)
            0: put_addr(29, 0, 1);
            1: put_addr(29, 1, 0);
            2: put_addr(35, 1, 27);
            3: put(31, 'hF1);
            4: put_addr(35, 75, 1);
            5: put(37, 'hF1);
            6: put_addr(75, 1, 4);
            7: put_addr(29, 1, 3);
            8: begin
               put_addr(35, 74, 26);
               put_addr(75, 75, 2);
            end
            9: put(77, 'hF1);
            10: put(42, 'hD7);
            11: put(27, 'hF0);
            12: put(25, 'hF2);
            default: put(41, label_pkg::CH_B);
         endcase
         start(label_pkg::OP_READ);
         send(1'b0, 8'd80, lbl);
         finish(32'h6, 32'h14, 32'h1F);
         `CHK(rd_cnt, 0)
      end
      // bypass on every data command, protect on both writes
      for (op = 0; op < 6; op++) begin
         lbl = base;
         put(op < 4 ? 41 : 43, op < 4 ? 'hC2 : 'hD7);
         start(op < 4 ? op : op - 2);
         send(1'b0, 8'd80, lbl);
         finish(32'h6, op < 4 ? 32'h14 : 32'hC, 32'h1F);
         `CHK(rd_cnt, 0)
      end
      // drive fault in label phase, then in data phase
      for (op = 0; op < 2; op++) begin
         start(label_pkg::OP_READ);
         if (op == 1) send(1'b0, 8'd80, base);
         flt <= 1'b1;
         @(posedge clk);
         flt <= 1'b0;
         finish(32'h6, op ? 32'h0 : 32'h4, 32'h1F);
      end
      // busy while running, then abort
      start(label_pkg::OP_READ);
      apb(1'b0, label_pkg::OFS_STATUS, 32'h0);
      `CHK(rdat, 32'h10)
      apb(1'b1, label_pkg::OFS_CTRL, 32'h200);
      finish(32'h4, 32'h0, 32'h1F);
      // write of two sectors fills the extent and stops at its end
      start(label_pkg::OP_WRITE);
      send(1'b0, 8'd80, base);
      repeat (2) send(1'b0, 8'd4, dat);
      finish(32'h4, 32'h0, 32'h1F);
      apb(1'b0, label_pkg::OFS_DEND, 32'h0);
      `CHK(rdat, 32'h00000083)
      // unmapped register
      apb(1'b0, 8'h20, 32'h0);
      `CHK(rerr, 1'b1)
      `CHK(rdat, 32'h0)
      print_verdict();
   end
endmodule // tb_top
